// *** src/bievs_top.sv ***
`timescale 1ns/1ps
// What this block does
// - after bus recovery stay inactive for configured 0..30000 s before sampling
// - when wait ends, sample input and react as if it just changed
// - recovery wait is separate from send delay, never added
// - each event sends nothing or a value of the configured type
// - sent value is a configured constant ranged by its type
// - forced code: upper bit clear frees, 10 forces off, 11 on
// - forced choice is on, off or release; emit matching code
// - scene type sends configured scene number 1 to 64
// - scene flag selects recall or save, recall by default
// - time type sends hour, minute and second fields
// - time telegram carries weekday, 0 none, 1..7 Monday..Sunday
// - second event has the same independent choices as the first
// - with distinction on, short press is event 0, long event 1
// - contact type selects closing or opening as actuation
// - long after selectable threshold 0.3 s .. 10 s, default 0.6 s
// - react at once on an edge, then ignore edges for debounce
module bievs_top #(
	parameter int CYC_PER_MS = bievs_pkg::CYC_PER_MS
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic IN_PIN,
	input wire logic BUS_OK,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic TX_VALID,
	output bievs_pkg::bievs_tx_t TX_DATA,
	output logic TX_EVENT
);
	typedef enum {S_DOWN, S_WAIT, S_RUN} bievs_state_t;
	bievs_state_t state_q;
	logic [31:0] ctrl_q, wait_q, cfg0_q, val0_q, cfg1_q, val1_q;
	logic in_s1_q, in_s2_q, bus_s1_q, bus_s2_q;
	logic [17:0] pre_q;
	logic tick_ms;
	logic [9:0] sec_pre_q;
	logic [14:0] wait_cnt_q;
	logic [7:0] deb_q;
	logic lvl_q, act_q, pend_q;
	logic [13:0] hold_q;
	logic fire, fire_ev;
	bievs_pkg::bievs_tx_t tx0, tx1;
	logic wr, rd;

	// debounce choice to milliseconds
	function automatic logic [7:0] deb_ms(input logic [2:0] sel);
		unique case (sel)
			3'h0: deb_ms = 8'd10;
			3'h1: deb_ms = 8'd20;
			3'h2: deb_ms = 8'd30;
			3'h3: deb_ms = 8'd50;
			3'h4: deb_ms = 8'd70;
			3'h5: deb_ms = 8'd100;
			default: deb_ms = 8'd150;
		endcase
	endfunction : deb_ms

	// long-press choice to milliseconds; index 8..16 are 2..10 s
	function automatic logic [13:0] long_ms(input logic [4:0] sel);
		unique case (sel)
			5'h0: long_ms = 14'd300;
			5'h1: long_ms = 14'd400;
			5'h2: long_ms = 14'd500;
			5'h3: long_ms = 14'd600;
			5'h4: long_ms = 14'd800;
			5'h5: long_ms = 14'd1000;
			5'h6: long_ms = 14'd1200;
			5'h7: long_ms = 14'd1500;
			default: long_ms = (sel > 5'h10) ? 14'd10000 : 14'((sel - 5'h6) * 14'd1000);
		endcase
	endfunction : long_ms

	// pin and bus-voltage sense are asynchronous
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			in_s1_q <= 1'b0;
			in_s2_q <= 1'b0;
			bus_s1_q <= 1'b0;
			bus_s2_q <= 1'b0;
		end else begin
			in_s1_q <= IN_PIN;
			in_s2_q <= in_s1_q;
			bus_s1_q <= BUS_OK;
			bus_s2_q <= bus_s1_q;
		end
	end

	// 1 ms timebase enable
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) pre_q <= 18'h0;
		else if (tick_ms) pre_q <= 18'h0;
		else pre_q <= pre_q + 18'h1;
	end
	assign tick_ms = (pre_q == 18'(CYC_PER_MS - 1));

	// apb slave, zero wait states, error on unmapped offsets
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && !PWRITE;
	assign PREADY = 1'b1;
	always_comb begin
		unique case (PADDR)
			bievs_pkg::ADDR_CTRL, bievs_pkg::ADDR_WAIT, bievs_pkg::ADDR_EV0_CFG, bievs_pkg::ADDR_EV0_VAL,
			bievs_pkg::ADDR_EV1_CFG, bievs_pkg::ADDR_EV1_VAL, bievs_pkg::ADDR_STATUS,
			bievs_pkg::ADDR_TX_TYPE, bievs_pkg::ADDR_TX_VAL: PSLVERR = 1'b0;
			default: PSLVERR = PSEL && PENABLE;
		endcase
	end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_q <= bievs_pkg::CTRL_RESET;
			wait_q <= 32'h0;
			cfg0_q <= bievs_pkg::CFG_RESET;
			val0_q <= 32'h0;
			cfg1_q <= bievs_pkg::CFG_RESET;
			val1_q <= 32'h0;
		end else if (wr) begin
			unique case (PADDR)
				bievs_pkg::ADDR_CTRL: ctrl_q <= PWDATA;
				// wait bits 14:0 saturate at the top of its range; higher bits are dropped
				bievs_pkg::ADDR_WAIT: wait_q <= {17'h0, (PWDATA[14:0] > bievs_pkg::WAIT_MAX_S) ?
					bievs_pkg::WAIT_MAX_S : PWDATA[14:0]};
				bievs_pkg::ADDR_EV0_CFG: cfg0_q <= PWDATA;
				bievs_pkg::ADDR_EV0_VAL: val0_q <= PWDATA;
				bievs_pkg::ADDR_EV1_CFG: cfg1_q <= PWDATA;
				bievs_pkg::ADDR_EV1_VAL: val1_q <= PWDATA;
				default: ;
			endcase
		end
	end
	// read data registered in the setup cycle so it is stable in access
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) PRDATA <= 32'h0;
		else if (rd && !PENABLE) begin
			unique case (PADDR)
				bievs_pkg::ADDR_CTRL: PRDATA <= ctrl_q;
				bievs_pkg::ADDR_WAIT: PRDATA <= wait_q;
				bievs_pkg::ADDR_EV0_CFG: PRDATA <= cfg0_q;
				bievs_pkg::ADDR_EV0_VAL: PRDATA <= val0_q;
				bievs_pkg::ADDR_EV1_CFG: PRDATA <= cfg1_q;
				bievs_pkg::ADDR_EV1_VAL: PRDATA <= val1_q;
				bievs_pkg::ADDR_STATUS: PRDATA <= {27'h0, pend_q, act_q, lvl_q, state_q == S_RUN, state_q == S_WAIT};
				bievs_pkg::ADDR_TX_TYPE: PRDATA <= {28'h0, TX_DATA.kind};
				bievs_pkg::ADDR_TX_VAL: PRDATA <= TX_DATA.value;
				default: PRDATA <= 32'h0;
			endcase
		end
	end

	// recovery wait; a new failure drops back to down and restarts from zero
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= S_DOWN;
			wait_cnt_q <= 15'h0;
			sec_pre_q <= 10'h0;
		end else if (!bus_s2_q) begin
			state_q <= S_DOWN;
			wait_cnt_q <= 15'h0;
			sec_pre_q <= 10'h0;
		end else begin
			unique case (state_q)
				S_DOWN: state_q <= S_WAIT;
				S_WAIT: begin
					if (wait_cnt_q >= wait_q[14:0]) state_q <= S_RUN;
					else if (tick_ms) begin
						if (sec_pre_q == 10'(bievs_pkg::MS_PER_S - 1)) begin
							sec_pre_q <= 10'h0;
							wait_cnt_q <= wait_cnt_q + 15'h1;
						end else sec_pre_q <= sec_pre_q + 10'h1;
					end
				end
				S_RUN: ;
			endcase
		end
	end

	// edge detection with debounce lockout; the last wait cycle (start) forces a rescan
	logic act_now, start;
	assign act_now = in_s2_q ^ ctrl_q[bievs_pkg::CTRL_CONTACT_OPEN];
	assign start = (state_q == S_WAIT) && (wait_cnt_q >= wait_q[14:0]);
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			lvl_q <= 1'b0;
			deb_q <= 8'h0;
		end else if (start) begin
			lvl_q <= act_now;
			deb_q <= deb_ms(ctrl_q[bievs_pkg::CTRL_DEB_LSB +: 3]);
		end else if (state_q == S_RUN) begin
			if (deb_q != 8'h0) begin
				if (tick_ms) deb_q <= deb_q - 8'h1;
			end else if (act_now != lvl_q) begin
				lvl_q <= act_now;
				deb_q <= deb_ms(ctrl_q[bievs_pkg::CTRL_DEB_LSB +: 3]);
			end
		end
	end
	logic edge_now;
	assign edge_now = start || (state_q == S_RUN && deb_q == 8'h0 && act_now != lvl_q);

	// short/long timing of an actuation
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			act_q <= 1'b0;
			pend_q <= 1'b0;
			hold_q <= 14'h0;
		end else if (state_q != S_RUN && !start) begin
			act_q <= 1'b0;
			pend_q <= 1'b0;
			hold_q <= 14'h0;
		end else if (edge_now) begin
			act_q <= act_now;
			pend_q <= act_now && ctrl_q[bievs_pkg::CTRL_DIST];
			hold_q <= 14'h0;
		end else if (pend_q && tick_ms) begin
			if (hold_q + 14'h1 >= long_ms(ctrl_q[bievs_pkg::CTRL_LONG_LSB +: 5])) pend_q <= 1'b0;
			else hold_q <= hold_q + 14'h1;
		end
	end

	// event selection: without distinction release is event 0, press event 1
	always_comb begin
		fire = 1'b0;
		fire_ev = 1'b0;
		if (ctrl_q[bievs_pkg::CTRL_DIST]) begin
			if (pend_q && edge_now && !act_now) begin
				fire = 1'b1;
				fire_ev = 1'b0;
			end else if (pend_q && state_q == S_RUN && !edge_now && tick_ms && // pend_q lingers one cycle after a bus drop
				hold_q + 14'h1 >= long_ms(ctrl_q[bievs_pkg::CTRL_LONG_LSB +: 5])) begin
				fire = 1'b1;
				fire_ev = 1'b1;
			end
		end else if (edge_now) begin
			fire = 1'b1;
			fire_ev = act_now;
		end
	end

	bievs_encode u_enc0 (
		.cfg(cfg0_q),
		.val(val0_q),
		.tx(tx0)
	);
	bievs_encode u_enc1 (
		.cfg(cfg1_q),
		.val(val1_q),
		.tx(tx1)
	);

	// telegram leaves registered, the cycle after the event; no send delay is stacked on the wait
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			TX_VALID <= 1'b0;
			TX_DATA <= '0;
			TX_EVENT <= 1'b0;
		end else begin
			TX_VALID <= 1'b0;
			if (fire && (fire_ev ? tx1.kind : tx0.kind) != bievs_pkg::BIEVS_NONE) begin
				TX_VALID <= 1'b1;
				TX_DATA <= fire_ev ? tx1 : tx0;
				TX_EVENT <= fire_ev;
			end
		end
	end

	property p_no_send_while_waiting;
		@(posedge CLK) disable iff (!RST_B) state_q != S_RUN && !start |=> !TX_VALID;
	endproperty
	a_no_send_while_waiting: assert property (p_no_send_while_waiting) else $error("telegram during wait");

	property p_rescan;
		@(posedge CLK) disable iff (!RST_B) start |=> lvl_q == $past(act_now);
	endproperty
	a_rescan: assert property (p_rescan) else $error("no rescan at wait end");

	property p_fail_restart;
		@(posedge CLK) disable iff (!RST_B) !bus_s2_q |=> state_q == S_DOWN && wait_cnt_q == 15'h0;
	endproperty
	a_fail_restart: assert property (p_fail_restart) else $error("wait not restarted");

	property p_send_next;
		@(posedge CLK) disable iff (!RST_B) fire && !fire_ev && tx0.kind != bievs_pkg::BIEVS_NONE |=> TX_VALID && !TX_EVENT;
	endproperty
	a_send_next: assert property (p_send_next) else $error("event 0 not sent");

	property p_none_silent;
		@(posedge CLK) disable iff (!RST_B) TX_VALID |-> TX_DATA.kind != bievs_pkg::BIEVS_NONE;
	endproperty
	a_none_silent: assert property (p_none_silent) else $error("sent a do-not-send event");

	property p_force_code;
		@(posedge CLK) disable iff (!RST_B) TX_VALID && TX_DATA.kind == bievs_pkg::BIEVS_FORCE |->
			TX_DATA.value[31:2] == 30'h0 && TX_DATA.value[1:0] != 2'h1;
	endproperty
	a_force_code: assert property (p_force_code) else $error("bad forced code");

	property p_deb_lock;
		@(posedge CLK) disable iff (!RST_B) state_q == S_RUN && deb_q != 8'h0 |=> $stable(lvl_q);
	endproperty
	a_deb_lock: assert property (p_deb_lock) else $error("edge taken in debounce");

	property p_short_is_ev0;
		@(posedge CLK) disable iff (!RST_B) ctrl_q[bievs_pkg::CTRL_DIST] && pend_q && edge_now && !act_now |-> fire && !fire_ev;
	endproperty
	a_short_is_ev0: assert property (p_short_is_ev0) else $error("short not event 0");

	// with distinction the press itself never sends; only release or threshold decides
	property p_press_waits;
		@(posedge CLK) disable iff (!RST_B) ctrl_q[bievs_pkg::CTRL_DIST] && edge_now && act_now |=> !TX_VALID;
	endproperty
	a_press_waits: assert property (p_press_waits) else $error("press sent before short or long known");
endmodule : bievs_top

// *** src/bievs_pkg.sv ***
package bievs_pkg;
	// apb register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WAIT = 8'h04;
	localparam logic [7:0] ADDR_EV0_CFG = 8'h08;
	localparam logic [7:0] ADDR_EV0_VAL = 8'h0c;
	localparam logic [7:0] ADDR_EV1_CFG = 8'h10;
	localparam logic [7:0] ADDR_EV1_VAL = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_TX_TYPE = 8'h1c;
	localparam logic [7:0] ADDR_TX_VAL = 8'h20;
	// ctrl field positions
	localparam int CTRL_DIST = 0;
	localparam int CTRL_CONTACT_OPEN = 1;
	localparam int CTRL_DEB_LSB = 4;
	localparam int CTRL_LONG_LSB = 8;
	// event cfg field positions
	localparam int CFG_SCENE_SAVE = 4;
	// reset values and the wait ceiling
	localparam logic [31:0] CTRL_RESET = 32'h0000_0320;
	localparam logic [31:0] CFG_RESET = 32'h0000_0004;
	localparam logic [14:0] WAIT_MAX_S = 15'h7530;
	// timebase: 1 ms tick at 250 MHz
	localparam int CLK_HZ = 250_000_000;
	localparam int TICK_NS = 1_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int MS_PER_S = 1000;
	// data types of a reaction
	typedef enum logic [3:0] {
		BIEVS_NONE, BIEVS_BIT1, BIEVS_FORCE, BIEVS_S8, BIEVS_U8, BIEVS_SCENE,
		BIEVS_S16, BIEVS_U16, BIEVS_F16, BIEVS_TOD, BIEVS_S32, BIEVS_U32
	} bievs_type_t;
	// forced-operation choices
	localparam logic [1:0] FORCE_CFG_ON = 2'h0;
	localparam logic [1:0] FORCE_CFG_OFF = 2'h1;
	localparam logic [1:0] FORCE_CODE_ON = 2'h3;
	localparam logic [1:0] FORCE_CODE_OFF = 2'h2;
	localparam logic [1:0] FORCE_CODE_FREE = 2'h0;
	// one telegram to the bus side
	typedef struct packed {
		bievs_type_t kind;
		logic [31:0] value;
	} bievs_tx_t;
endpackage : bievs_pkg

// *** src/bievs_encode.sv ***
`timescale 1ns/1ps
// turns a reaction configuration into the value sent on the bus
module bievs_encode (
	input wire logic [31:0] cfg,
	input wire logic [31:0] val,
	output bievs_pkg::bievs_tx_t tx
);
	bievs_pkg::bievs_type_t kind;
	assign kind = bievs_pkg::bievs_type_t'(cfg[3:0]);
	// range of the constant follows the selected type
	always_comb begin
		tx.kind = kind;
		tx.value = 32'h0000_0000;
		unique case (kind)
			bievs_pkg::BIEVS_NONE: tx.value = 32'h0000_0000;
			bievs_pkg::BIEVS_BIT1: tx.value = {31'h0, val[0]};
			bievs_pkg::BIEVS_FORCE: begin
				// upper bit clear releases forcing
				if (val[1:0] == bievs_pkg::FORCE_CFG_ON) tx.value = {30'h0, bievs_pkg::FORCE_CODE_ON};
				else if (val[1:0] == bievs_pkg::FORCE_CFG_OFF) tx.value = {30'h0, bievs_pkg::FORCE_CODE_OFF};
				else tx.value = {30'h0, bievs_pkg::FORCE_CODE_FREE};
			end
			bievs_pkg::BIEVS_S8, bievs_pkg::BIEVS_U8: tx.value = {24'h0, val[7:0]};
			bievs_pkg::BIEVS_SCENE: begin
				// scene 1..64 travels as 0..63, bit 7 set means save
				tx.value = {24'h0, cfg[bievs_pkg::CFG_SCENE_SAVE], 1'b0, 6'(val[5:0] - 6'h01)};
			end
			bievs_pkg::BIEVS_S16, bievs_pkg::BIEVS_U16, bievs_pkg::BIEVS_F16: tx.value = {16'h0, val[15:0]};
			bievs_pkg::BIEVS_TOD: begin
				// weekday in top three bits of the hour byte
				tx.value = {8'h0, val[26:24], val[20:16], 2'h0, val[13:8], 2'h0, val[5:0]};
			end
			bievs_pkg::BIEVS_S32, bievs_pkg::BIEVS_U32: tx.value = val;
			default: tx.value = 32'h0000_0000; // unused codes send zero
		endcase
	end
endmodule : bievs_encode

// *** dv/bievs_bus_model.sv ***
`timescale 1ns/1ps
// receiving side of the field bus: catches every telegram that leaves the block
module bievs_bus_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tx_valid,
	input wire bievs_pkg::bievs_tx_t tx_data,
	input wire logic tx_event,
	output int count_q,
	output bievs_pkg::bievs_tx_t last_q,
	output logic last_event_q
);
	// a telegram is a one-cycle pulse, so it is taken on that very edge or lost
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 0;
			last_q <= '0;
			last_event_q <= 1'b0;
		end else if (tx_valid) begin
			count_q <= count_q + 1;
			last_q <= tx_data;
			last_event_q <= tx_event;
		end
	end
endmodule : bievs_bus_model

// *** dv/bievs_top_bench.sv ***
`timescale 1ns/1ps
// drives the contact pin, bus voltage and apb; the bus model collects telegrams
module bievs_top_bench;
	localparam int CPM = 10;
	localparam int DEB = 30 * CPM;
	logic CLK, RST_B, IN_PIN, BUS_OK, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TX_VALID, TX_EVENT;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	bievs_pkg::bievs_tx_t TX_DATA, last;
	logic last_event, err;
	int count, base, mismatches, samples_checked;
	typedef struct {logic [31:0] cfg; logic [31:0] val; logic [3:0] kind; logic [31:0] sent;} bievs_row_t;
	// event 1 setting, value, expected kind and sent value
	bievs_row_t rows [15] = '{
		'{32'h2, 32'h0, 4'h2, 32'h3},
		'{32'h2, 32'h1, 4'h2, 32'h2},
		'{32'h2, 32'h2, 4'h2, 32'h0},
		'{32'h5, 32'h40, 4'h5, 32'h3f},
		'{32'h15, 32'h1, 4'h5, 32'h80},
		'{32'h9, 32'h0717_3b3b, 4'h9, 32'h00f7_3b3b},
		'{32'h9, 32'h0100_0000, 4'h9, 32'h0020_0000},
		'{32'h4, 32'hff, 4'h4, 32'hff},
		'{32'h1, 32'h1, 4'h1, 32'h1},
		'{32'h3, 32'hffff_ff80, 4'h3, 32'h80},
		'{32'h6, 32'h1234_8001, 4'h6, 32'h8001},
		'{32'h7, 32'hffff_ffff, 4'h7, 32'hffff},
		'{32'h8, 32'h0001_0c1a, 4'h8, 32'h0c1a},
		'{32'ha, 32'h8000_0000, 4'ha, 32'h8000_0000},
		'{32'hb, 32'hffff_ffff, 4'hb, 32'hffff_ffff}
	};
	bievs_top #(.CYC_PER_MS(CPM)) dut (.CLK(CLK), .RST_B(RST_B), .IN_PIN(IN_PIN), .BUS_OK(BUS_OK),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_EVENT(TX_EVENT));
	bievs_bus_model bus (.clk(CLK), .rst_b(RST_B), .tx_valid(TX_VALID), .tx_data(TX_DATA),
		.tx_event(TX_EVENT), .count_q(count), .last_q(last), .last_event_q(last_event));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one apb transfer; the request stands until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		// no cap here: only the watchdog ends a hung access
		while (PREADY !== 1'b1) begin
			@(posedge CLK);
			n++;
		end
		check("wait states", 32'h0, n);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic pin(input logic v);
		@(posedge CLK);
		IN_PIN <= v;
	endtask : pin
	task automatic idle(input int c);
		repeat (c) @(posedge CLK);
	endtask : idle
	// nothing may leave during this span
	task automatic quiet(input int c);
		idle(c);
		#1;
		check("no telegram", base, count);
	endtask : quiet
	// bounded wait for the next telegram, then compare it whole
	task automatic expect_tx(input int lim, input logic ev, input logic [3:0] k, input logic [31:0] v);
		int n;
		n = 0;
		while (count == base && n < lim) begin
			@(posedge CLK);
			n++;
		end
		#1;
		check("telegram count", base + 1, count);
		check("event", ev, last_event);
		check("kind", k, last.kind);
		check("value", v, last.value);
		base = count;
	endtask : expect_tx
	task automatic close_out;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	// whole run is near 35k cycles; this cuts a hang short
	initial begin
		idle(60000);
		mismatches++;
		close_out();
	end
	initial begin
		RST_B = 1'b0;
		IN_PIN = 1'b0;
		BUS_OK = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = '0;
		PWDATA = '0;
		mismatches = 0;
		samples_checked = 0;
		base = 0;
		idle(5);
		RST_B <= 1'b1;
		apb(1'b0, bievs_pkg::ADDR_CTRL, 32'h0);
		check("ctrl reset", bievs_pkg::CTRL_RESET, rd);
		apb(1'b0, bievs_pkg::ADDR_WAIT, 32'h0);
		check("wait reset", 32'h0, rd);
		apb(1'b1, 8'h40, 32'h1);
		check("unmapped error", 1'b1, err);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped read", 32'h0, rd);
		check("unmapped read error", 1'b1, err);
		apb(1'b0, bievs_pkg::ADDR_EV0_CFG, 32'h0);
		check("event cfg reset", 32'h0000_0004, rd);
		apb(1'b1, bievs_pkg::ADDR_WAIT, 32'hffff_ffff);
		apb(1'b0, bievs_pkg::ADDR_WAIT, 32'h0);
		check("wait ceiling", {17'h0, bievs_pkg::WAIT_MAX_S}, rd);
		apb(1'b1, bievs_pkg::ADDR_WAIT, 32'h0);
		apb(1'b1, bievs_pkg::ADDR_EV0_CFG, 32'h4);
		apb(1'b1, bievs_pkg::ADDR_EV0_VAL, 32'h5a);
		// zero wait: recovery rescans at once and reports the released level
		BUS_OK <= 1'b1;
		expect_tx(40, 1'b0, 4'h4, 32'h5a);
		// the rescan arms the debounce lockout, so let it run out
		idle(DEB + 20);
		foreach (rows[i]) begin
			apb(1'b1, bievs_pkg::ADDR_EV1_CFG, rows[i].cfg);
			apb(1'b1, bievs_pkg::ADDR_EV1_VAL, rows[i].val);
			pin(1'b1);
			expect_tx(40, 1'b1, rows[i].kind, rows[i].sent);
			idle(DEB + 20);
			pin(1'b0);
			expect_tx(40, 1'b0, 4'h4, 32'h5a);
			idle(DEB + 20);
		end
		// bounces inside the debounce span are ignored
		pin(1'b1);
		expect_tx(40, 1'b1, 4'hb, 32'hffff_ffff);
		idle(50);
		IN_PIN <= 1'b0;
		idle(50);
		IN_PIN <= 1'b1;
		quiet(DEB);
		pin(1'b0);
		expect_tx(40, 1'b0, 4'h4, 32'h5a);
		idle(DEB + 20);
		// short press gives event 0 on release, long gives event 1 at the threshold
		apb(1'b1, bievs_pkg::ADDR_CTRL, bievs_pkg::CTRL_RESET | 32'h1);
		pin(1'b1);
		quiet(100 * CPM);
		pin(1'b0);
		expect_tx(40, 1'b0, 4'h4, 32'h5a);
		idle(DEB + 20);
		pin(1'b1);
		quiet(590 * CPM);
		expect_tx(20 * CPM, 1'b1, 4'hb, 32'hffff_ffff);
		pin(1'b0);
		idle(DEB + 20);
		check("no telegram", base, count);
		// opening contact; a bus drop mid-wait restarts the one second wait
		BUS_OK <= 1'b0;
		apb(1'b1, bievs_pkg::ADDR_CTRL, bievs_pkg::CTRL_RESET | 32'h2);
		apb(1'b1, bievs_pkg::ADDR_WAIT, 32'h1);
		BUS_OK <= 1'b1;
		idle(500 * CPM);
		BUS_OK <= 1'b0;
		idle(20);
		BUS_OK <= 1'b1;
		quiet(990 * CPM);
		expect_tx(20 * CPM + 40, 1'b1, 4'hb, 32'hffff_ffff);
		idle(DEB + 20);
		pin(1'b1);
		expect_tx(40, 1'b0, 4'h4, 32'h5a);
		// do-not-send event stays silent; registers mirror the last telegram
		idle(DEB + 20);
		apb(1'b1, bievs_pkg::ADDR_EV1_CFG, 32'h0);
		pin(1'b0);
		quiet(DEB + 20);
		pin(1'b1);
		expect_tx(40, 1'b0, 4'h4, 32'h5a);
		apb(1'b0, bievs_pkg::ADDR_TX_TYPE, 32'h0);
		check("tx kind reg", 32'h4, rd);
		apb(1'b0, bievs_pkg::ADDR_TX_VAL, 32'h0);
		check("tx value reg", 32'h5a, rd);
		apb(1'b0, bievs_pkg::ADDR_STATUS, 32'h0);
		check("status", 32'h2, rd);
		// reset in mid-run with the bus up: the rescan reacts with the reset settings
		RST_B <= 1'b0;
		idle(5);
		RST_B <= 1'b1;
		base = 0;
		expect_tx(40, 1'b1, 4'h4, 32'h0);
		apb(1'b0, bievs_pkg::ADDR_EV1_CFG, 32'h0);
		check("event cfg reset", 32'h0000_0004, rd);
		apb(1'b0, bievs_pkg::ADDR_CTRL, 32'h0);
		check("ctrl reset", bievs_pkg::CTRL_RESET, rd);
		close_out();
	end
endmodule : bievs_top_bench
